// File: hdl/adcc_map.vh
// register map, field positions and timing counts of the converter control
// Summary of operation
// - upper result holds result bits 9:8 in bits 1:0; bits 7:2 read zero.
// - lower result holds result bits 7:0; read only, undefined after reset.
// - result is ten bits, 1024 steps, no sign extension upward.
// - unimplemented bits read zero and ignore writes.
// - setting start/done begins conversion; hardware clears it when done.
// - enable clear keeps converter off; setting it enables converter.
// - 5-bit channel field selects input; external pins from code 11000.
// - no conversion while processor sleeps; sleep aborts it and clears start/done.
`ifndef ADCC_MAP_VH
`define ADCC_MAP_VH
`define ADCC_OFS_CHAN_START  3'h0
`define ADCC_OFS_CLK_REF     3'h1
`define ADCC_OFS_RES_UPPER   3'h2
`define ADCC_OFS_RES_LOWER   3'h3
`define ADCC_OFS_IRQ_STATUS  3'h4
`define ADCC_OFS_IRQ_MASK    3'h5
`define ADCC_BIT_ENABLE      0
`define ADCC_BIT_START       1
`define ADCC_CHAN_LSB        2
`define ADCC_CHAN_MSB        6
`define ADCC_CLK_LSB         4
`define ADCC_CLK_MSB         6
`define ADCC_BIT_REF         0
`define ADCC_CHAN_WMASK      8'h7F
`define ADCC_CLK_WMASK       8'h71
`define ADCC_CHAN_EXT_FIRST  5'h18
`define ADCC_CLK_OSC         3'h3
`define ADCC_CLK_RES0        3'h7
`define ADCC_CONV_BITS       10
`define ADCC_TAD_PER_CONV    5'h0B
`define ADCC_OSC_DIV         8'h10
`define ADCC_DIV_CODE0       6'h01
`define ADCC_DIV_CODE1       6'h07
`define ADCC_DIV_CODE2       6'h1F
`define ADCC_DIV_CODE4       6'h03
`define ADCC_DIV_CODE5       6'h0F
`define ADCC_DIV_CODE6       6'h3F
`endif

// File: hdl/adcc_sar.v
// successive-approximation sequencer for one ten-bit conversion
module adcc_sar (
    clk,
    srst,
    tick,
    start,
    abort,
    cmp_in,
    dac_code,
    busy,
    done,
    result
);
`include "adcc_map.vh"
    input             clk;
    input             srst;
    input             tick;
    input             start;
    input             abort;
    input             cmp_in;
    output     [9:0]  dac_code;
    output            busy;
    output            done;
    output     [9:0]  result;
    reg        [9:0]  trial_reg;
    reg        [9:0]  bit_reg;
    reg               busy_reg;
    reg               done_reg;
    reg        [9:0]  result_reg;
    assign dac_code = trial_reg | bit_reg;
    assign busy = busy_reg;
    assign done = done_reg;
    assign result = result_reg;
    always @(posedge clk) begin
        done_reg <= 1'b0;
        if (srst || abort) begin
            busy_reg  <= 1'b0;
            trial_reg <= 10'h000;
            bit_reg   <= 10'h000;
        end else if (start && !busy_reg && !done_reg) begin
            busy_reg  <= 1'b1;
            trial_reg <= 10'h000;
            bit_reg   <= 10'h200;
        end else if (busy_reg && tick) begin
            // keep the trial bit when the input is above the dac level
            if (cmp_in)
                trial_reg <= trial_reg | bit_reg;
            bit_reg <= bit_reg >> 1;
            if (bit_reg == 10'h001) begin
                busy_reg   <= 1'b0;
                done_reg   <= 1'b1;
                result_reg <= cmp_in ? (trial_reg | bit_reg) : trial_reg;
            end
        end
    end
endmodule // adcc_sar

// File: hdl/adcc_top.v
// converter control and result registers with interrupt
//
// Design decisions made here: the strobed register port and the register offsets.
module adcc_top (
    clk,
    srst,
    addr,
    wdata,
    wr_stb,
    rd_stb,
    rdata,
    sleep,
    osc_tick,
    cmp_in,
    dac_code,
    analog_on,
    ref_select,
    channel,
    irq
);
`include "adcc_map.vh"
    input             clk;
    input             srst;
    input      [2:0]  addr;
    input      [7:0]  wdata;
    input             wr_stb;
    input             rd_stb;
    output     [7:0]  rdata;
    input             sleep;
    input             osc_tick;
    input             cmp_in;
    output     [9:0]  dac_code;
    output            analog_on;
    output            ref_select;
    output     [4:0]  channel;
    output            irq;

    reg               enable_reg;
    reg               start_reg;
    reg        [4:0]  chan_reg;
    reg        [2:0]  clksel_reg;
    reg               ref_reg;
    reg               flag_reg;
    reg               mask_reg;
    reg        [7:0]  rdata_reg;
    reg        [7:0]  rdata_next;
    reg        [5:0]  div_reg;
    reg        [5:0]  div_lim;
    reg               tick_reg;
    wire              busy;
    wire              done;
    wire       [9:0]  result;
    wire              wr_chan;
    wire              run;

    // write strobe aimed at one register offset
    function wr_hit;
        input             we;
        input      [2:0]  a;
        input      [2:0]  ofs;
        begin
            wr_hit = we && (a == ofs);
        end
    endfunction

    assign wr_chan    = wr_hit(wr_stb, addr, `ADCC_OFS_CHAN_START);
    assign run        = enable_reg && !sleep;
    assign analog_on  = run;
    assign ref_select = ref_reg;
    assign channel    = chan_reg;
    assign irq        = flag_reg && mask_reg;
    assign rdata      = rdata_reg;

    // divider terminal count from the clock field
    always @* begin
        case (clksel_reg)
            3'h0:    div_lim = `ADCC_DIV_CODE0;
            3'h1:    div_lim = `ADCC_DIV_CODE1;
            3'h2:    div_lim = `ADCC_DIV_CODE2;
            3'h4:    div_lim = `ADCC_DIV_CODE4;
            3'h5:    div_lim = `ADCC_DIV_CODE5;
            3'h6:    div_lim = `ADCC_DIV_CODE6;
            default: div_lim = 6'h00;
        endcase
    end

    // conversion clock: divided system clock or oscillator ticks
    always @(posedge clk) begin
        if (srst || !busy) begin
            div_reg  <= 6'h00;
            tick_reg <= 1'b0;
        end else if (clksel_reg == `ADCC_CLK_OSC ||
                     clksel_reg == `ADCC_CLK_RES0) begin
            tick_reg <= osc_tick;
        end else if (div_reg == div_lim) begin
            div_reg  <= 6'h00;
            tick_reg <= 1'b1;
        end else begin
            div_reg  <= div_reg + 6'h01;
            tick_reg <= 1'b0;
        end
    end

    adcc_sar u_sar (
        .clk      (clk),
        .srst     (srst),
        .tick     (tick_reg),
        .start    (start_reg && run),
        .abort    (!run),
        .cmp_in   (cmp_in),
        .dac_code (dac_code),
        .busy     (busy),
        .done     (done),
        .result   (result)
    );

    // control registers
    always @(posedge clk) begin
        if (srst) begin
            enable_reg <= 1'b0;
            start_reg  <= 1'b0;
            chan_reg   <= 5'h00;
            clksel_reg <= 3'h0;
            ref_reg    <= 1'b0;
            mask_reg   <= 1'b0;
        end else begin
            if (wr_chan) begin
                enable_reg <= wdata[`ADCC_BIT_ENABLE];
                chan_reg   <= wdata[`ADCC_CHAN_MSB:`ADCC_CHAN_LSB];
            end
            // hardware clear on completion or power-down
            if (done || !run)
                start_reg <= 1'b0;
            else if (wr_chan)
                start_reg <= wdata[`ADCC_BIT_START];
            if (wr_hit(wr_stb, addr, `ADCC_OFS_CLK_REF)) begin
                clksel_reg <= wdata[`ADCC_CLK_MSB:`ADCC_CLK_LSB];
                ref_reg    <= wdata[`ADCC_BIT_REF];
            end
            if (wr_hit(wr_stb, addr, `ADCC_OFS_IRQ_MASK))
                mask_reg <= wdata[0];
        end
    end

    // sticky done flag, set wins over write-one clear
    always @(posedge clk) begin
        if (srst)
            flag_reg <= 1'b0;
        else if (done)
            flag_reg <= 1'b1;
        else if (wr_hit(wr_stb, addr, `ADCC_OFS_IRQ_STATUS) && wdata[0])
            flag_reg <= 1'b0;
    end

    // read mux
    always @* begin
        rdata_next = 8'h00;
        case (addr)
            `ADCC_OFS_CHAN_START:
                rdata_next = {1'b0, chan_reg, start_reg, enable_reg};
            `ADCC_OFS_CLK_REF:
                rdata_next = {1'b0, clksel_reg, 3'h0, ref_reg};
            `ADCC_OFS_RES_UPPER:
                rdata_next = {6'h00, result[9:8]};
            `ADCC_OFS_RES_LOWER:
                rdata_next = result[7:0];
            `ADCC_OFS_IRQ_STATUS:
                rdata_next = {7'h00, flag_reg};
            `ADCC_OFS_IRQ_MASK:
                rdata_next = {7'h00, mask_reg};
            default:
                rdata_next = 8'h00;
        endcase
    end

    always @(posedge clk) begin
        if (srst)
            rdata_reg <= 8'h00;
        else if (rd_stb)
            rdata_reg <= rdata_next;
        else
            rdata_reg <= 8'h00;
    end
endmodule // adcc_top

// File: dv/adcc_checker.sv
// assertion checker for the converter control top
module adcc_checker (
    input logic       clk, srst, wr_stb, rd_stb, sleep, osc_tick, cmp_in,
    input logic       analog_on, ref_select, irq,
    input logic [2:0] addr,
    input logic [7:0] wdata, rdata,
    input logic [9:0] dac_code,
    input logic [4:0] channel
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    a_rdata_idle: assert property (!rd_stb |=> rdata == 8'h00)
        else $error("rdata not idle");
    a_upper_zero: assert property (rd_stb && addr == 3'h2 |=>
        rdata[7:2] == 6'h00) else $error("upper bits set");
    a_unmapped_zero: assert property (rd_stb && addr > 3'h5 |=>
        rdata == 8'h00) else $error("unmapped read");
    a_sleep_off: assert property (sleep |-> !analog_on)
        else $error("on in sleep");
    a_chan_write: assert property (wr_stb && addr == 3'h0 |=>
        channel == $past(wdata[6:2])) else $error("channel");
    a_chan_hold: assert property (!(wr_stb && addr == 3'h0) |=>
        $stable(channel)) else $error("channel moved");
    a_ref_write: assert property (wr_stb && addr == 3'h1 |=>
        ref_select == $past(wdata[0])) else $error("ref");
    a_mask_off: assert property (wr_stb && addr == 3'h5 |=>
        !irq || $past(wdata[0])) else $error("irq masked");
    a_off_idle: assert property (!analog_on |=> dac_code == 10'h000)
        else $error("dac active while off");
endmodule // adcc_checker
bind adcc_top adcc_checker u_chk (.clk(clk), .srst(srst), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .sleep(sleep), .osc_tick(osc_tick), .cmp_in(cmp_in),
    .analog_on(analog_on), .ref_select(ref_select), .irq(irq), .addr(addr),
    .wdata(wdata), .rdata(rdata), .dac_code(dac_code), .channel(channel));

// File: dv/tb_top.sv
// self-checking bench for the converter control top
`define CHK(n,e,v) begin checked++; if ((v) !== (e)) begin errors++; \
    $display("wrong value %s exp %h got %h", n, e, v); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 0, srst = 1, wr_stb = 0, rd_stb = 0, sleep = 0;
    logic        osc_tick = 0, rd_d = 0, analog_on, ref_select, irq;
    logic [2:0]  addr = 0;
    logic [7:0]  wdata = 0, rdata, last;
    logic [9:0]  dac_code, vin = 0;
    logic [4:0]  channel, ch;
    logic [3:0]  tc = 0;
    logic [15:0] e, q[$];
    integer      errors = 0, checked = 0, s = 32'hC70B6151, i, c;
    wire         cmp_in = vin >= dac_code;
    always #12.5 clk = ~clk;
    adcc_top dut (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .sleep(sleep),
        .osc_tick(osc_tick), .cmp_in(cmp_in), .dac_code(dac_code),
        .analog_on(analog_on), .ref_select(ref_select), .channel(channel),
        .irq(irq));
    always @(posedge clk) begin
        tc <= tc + 4'h1;
        osc_tick <= tc == 4'hF;
        rd_d <= rd_stb;
        if (rd_d) begin
            e = q.pop_front();
            last <= rdata;
            `CHK("rdata", e[7:0], rdata & e[15:8])
        end
    end
    task final_report;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task acc(input logic w, input logic [2:0] a, input logic [7:0] d, m);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_stb <= w;
        rd_stb <= !w;
        if (!w) q.push_back({m, d & m});
        @(posedge clk);
        wr_stb <= 0;
        rd_stb <= 0;
        @(negedge clk);
    endtask
    task poll;
        for (i = 0; i < 3000; i++) begin
            acc(0, 3'h0, 8'h01, 8'h01);
            @(negedge clk);
            if (last[1] === 1'b0) return;
        end
        `CHK("done", 1'b0, last[1])
        final_report;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        srst <= 0;
        for (c = 0; c < 6; c++) acc(0, c, 0, c / 2 == 1 ? 0 : 8'hFF);
        acc(1, 3'h1, 8'hFF, 0);
        acc(0, 3'h1, 8'h71, 8'hFF);
        acc(1, 3'h6, 8'hFF, 0);
        acc(0, 3'h6, 8'h00, 8'hFF);
        acc(0, 3'h7, 8'h00, 8'hFF);
        acc(1, 3'h0, 8'h82, 0);
        acc(0, 3'h0, 8'h00, 8'hFF);
        `CHK("on", 1'b0, analog_on)
        $display("test regs done");
        acc(1, 3'h5, 8'h01, 0);
        for (c = 0; c < 8; c++) begin
            vin = $random(s);
            ch = $random(s);
            acc(1, 3'h1, {1'b0, c[2:0], 3'h0, c[0]}, 0);
            acc(1, 3'h0, {1'b0, ch, 2'h1}, 0);
            `CHK("on", 1'b1, analog_on)
            `CHK("chan", ch, channel)
            repeat (8) @(posedge clk);
            acc(1, 3'h0, {1'b0, ch, 2'h3}, 0);
            poll;
            acc(0, 3'h2, {6'h00, vin[9:8]}, 8'hFF);
            acc(0, 3'h3, vin[7:0], 8'hFF);
            `CHK("irq", 1'b1, irq)
            acc(1, 3'h5, 8'h00, 0);
            `CHK("irq", 1'b0, irq)
            acc(1, 3'h5, 8'h01, 0);
            `CHK("irq", 1'b1, irq)
            acc(1, 3'h4, 8'h01, 0);
            `CHK("irq", 1'b0, irq)
            $display("test clock code %0d done", c);
        end
        acc(1, 3'h1, 8'h60, 0);
        acc(1, 3'h0, 8'h03, 0);
        @(posedge clk);
        sleep <= 1;
        repeat (3) @(posedge clk);
        `CHK("on", 1'b0, analog_on)
        acc(0, 3'h0, 8'h01, 8'h03);
        @(posedge clk);
        sleep <= 0;
        repeat (700) @(posedge clk);
        @(negedge clk);
        `CHK("on", 1'b1, analog_on)
        `CHK("irq", 1'b0, irq)
        $display("test sleep done");
        final_report;
    end
endmodule // tb_top
